/* File: src/qdsc_consts.vh */
// Constants for the quad DAC two-wire command port
`ifndef QDSC_CONSTS_VH
`define QDSC_CONSTS_VH
// ----------------------------------------
// Address and command fields
// ----------------------------------------
`define QDSC_ADDR_FIXED 3'h2
`define QDSC_CMD_WRITE 2'h0
`define QDSC_CMD_READ 2'h2
`define QDSC_SEL_COPY 2'h0
`define QDSC_SEL_LIVE 2'h1
`define QDSC_SEL_STORED 2'h2
`define QDSC_SEL_BOTH 2'h3
`define QDSC_CH_ALL 4'hf
`define QDSC_CH_CTRL 4'h4
`define QDSC_CH_LAST 4'h3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define QDSC_STORED_CTRL_RST 8'h00
`define QDSC_STORED_VAL_RST 8'h00
`define QDSC_INIT_TIME_NS 500000
`define QDSC_CLK_PERIOD_NS 8
`define QDSC_INIT_CYCLES (`QDSC_INIT_TIME_NS / `QDSC_CLK_PERIOD_NS)
`define QDSC_COMMIT_PULSE 8'h19
`define QDSC_CMD_ACK_PULSE 8'h12
`endif

/* File: src/qdsc_port.v */
// Two-wire slave command port and register logic of a quad 8-bit DAC
`timescale 1ns/1ps
`include "qdsc_consts.vh"
module qdsc_port #(
  parameter INIT_CYCLES = `QDSC_INIT_CYCLES // Power-on mute period in clocks
) (
  // Clock, reset, enable
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  // Two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_b,
  // Straps and asynchronous mute pin
  input wire [3:0] address_strap_pins,
  input wire mute_pin_b,
  // Converter drive: one code byte, one mute bit and one power-down bit per channel
  output reg [31:0] dac_code,
  output reg [3:0] dac_muted,
  output reg [3:0] dac_powered_down
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] scl_sync_q;
  reg [2:0] sda_sync_q;
  reg scl_q; // Filtered clock level
  reg sda_q; // Filtered data level

  // Both bus lines come from another clock domain. The first stage may
  // go metastable, so only stages two and three are compared, and a
  // level seen for one sample only is dropped as a glitch.
  // Three stages; a change counts once stages two and three agree
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
    end
  end

  // ----------------------------------------
  // Bus event detection
  // ----------------------------------------
  // The next filtered level is formed here so an edge is flagged in the
  // cycle the filter accepts it. Both lines share one filter depth, so
  // their order on the wire survives, which START and STOP rely on.
  // Bus events, each one clock wide
  wire scl_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
  wire sda_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
  wire scl_rise = clk_en & scl_d & ~scl_q;
  wire scl_fall = clk_en & ~scl_d & scl_q;
  wire start_ev = clk_en & scl_q & scl_d & sda_q & ~sda_d;
  wire stop_ev = clk_en & scl_q & scl_d & ~sda_q & sda_d;

  // ----------------------------------------
  // Asynchronous mute pin
  // ----------------------------------------
  // The pin sets the hold flops at once, so muting needs no bus clock.
  // Release is clocked through two stages so unmute cannot race the
  // output register.
  // Asynchronous mute pin, held in reset-style flop
  reg [1:0] mute_sync_q;
  always @(posedge clock or negedge mute_pin_b) begin
    if (!mute_pin_b) begin
      mute_sync_q <= 2'b11;
    end else if (clk_en) begin
      mute_sync_q <= {mute_sync_q[0], 1'b0};
    end
  end

  // ----------------------------------------
  // Protocol state machine
  // ----------------------------------------
  localparam ST_IDLE = 5'b00001; // Waiting for START
  localparam ST_ADDR = 5'b00010; // Shifting address byte
  localparam ST_CMD = 5'b00100; // Shifting command byte
  localparam ST_DATA = 5'b01000; // Shifting data byte in
  localparam ST_READ = 5'b10000; // Shifting register byte out

  // One-hot state keeps each decode to a single bit compare.
  // There is no separate acknowledge state: the acknowledge slot is
  // the ninth pulse of the byte, by which an address or command byte has already moved the state on.
  reg [4:0] state_q;
  reg [3:0] bit_cnt_q; // Clock pulses within the byte, 0 to 8
  reg [7:0] shift_q; // Incoming byte
  reg [7:0] tx_q; // Outgoing byte
  reg [7:0] cmd_q; // Latched command byte
  reg cmd_valid_q; // Command byte held for a read phase
  reg ack_q; // Driving acknowledge low
  reg rd_ack_q; // Ninth pulse of a read byte
  reg [7:0] pulse_cnt_q; // Clock pulses since address START

  // Live copies drive the converters; stored copies stand for the
  // nonvolatile bytes. Only rst_b clears them, which models the first
  // power-up of a fresh device.
  // Channel and control storage
  reg [7:0] live_channel_value [0:3];
  reg [7:0] stored_channel_value [0:3];
  reg [7:0] live_output_control;
  reg [7:0] stored_output_control;

  // The timer runs once after reset; with the clock enable low it stops,
  // so the mute period stretches by the time spent frozen.
  // Power-on load and mute timer
  reg [19:0] init_cnt_q;
  reg init_busy_q;

  // ----------------------------------------
  // Command decoding helpers
  // ----------------------------------------
  // The read data path and the commit path both ask whether a command
  // is legal, so the decode lives in one function. Anything rejected is
  // still acknowledged on the bus but never touches a register.
  // Command classification helper
  function cmd_ok;
    input [7:0] c;
    begin
      cmd_ok = 1'b0;
      if (c[7:6] == `QDSC_CMD_WRITE) begin
        if (c[3:0] <= `QDSC_CH_LAST || c[3:0] == `QDSC_CH_CTRL) begin
          cmd_ok = 1'b1;
        end else if (c[3:0] == `QDSC_CH_ALL && c[5:4] == `QDSC_SEL_LIVE) begin
          cmd_ok = 1'b1;
        end
      end else if (c[7:6] == `QDSC_CMD_READ) begin
        if ((c[5:4] == `QDSC_SEL_LIVE || c[5:4] == `QDSC_SEL_STORED) &&
            (c[3:0] <= `QDSC_CH_LAST || c[3:0] == `QDSC_CH_CTRL)) begin
          cmd_ok = 1'b1;
        end
      end
    end
  endfunction

  // Select bit five picks the stored copy; control register reads use
  // the same selection as channel reads.
  // Register picked by a read command
  function [7:0] read_pick;
    input [7:0] c;
    input [31:0] lv;
    input [31:0] sv;
    input [7:0] lc;
    input [7:0] sc;
    begin
      if (c[3:0] == `QDSC_CH_CTRL) begin
        read_pick = c[5] ? sc : lc;
      end else begin
        read_pick = c[5] ? sv[{c[1:0], 3'b000} +: 8] : lv[{c[1:0], 3'b000} +: 8];
      end
    end
  endfunction

  // Functions cannot take arrays as arguments, hence the flat vectors
  // Flat views of the arrays for the read function
  wire [31:0] live_flat = {live_channel_value[3], live_channel_value[2],
                           live_channel_value[1], live_channel_value[0]};
  wire [31:0] stored_flat = {stored_channel_value[3], stored_channel_value[2],
                             stored_channel_value[1], stored_channel_value[0]};

  // ----------------------------------------
  // Write commit
  // ----------------------------------------
  // The commit waits for the last data bit itself, not the acknowledge
  // after it; a STOP or START that cuts the byte short changes nothing.
  // Commit strobe: rising edge of the last data bit is the 26th overall
  wire commit = scl_rise & (state_q == ST_DATA) & (bit_cnt_q == 4'h7) &
                (pulse_cnt_q == `QDSC_COMMIT_PULSE) & cmd_ok(cmd_q) &
                (cmd_q[7:6] == `QDSC_CMD_WRITE);
  wire [7:0] wr_byte = {shift_q[6:0], sda_q};
  integer i;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  // Bits are taken on rising bus clock edges and the data line is only
  // moved after falling edges, so the device never changes it while the
  // bus clock is high, where a change would read as START or STOP.
  // Byte engine and register updates
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      ack_q <= 1'b0;
      rd_ack_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        live_channel_value[i] <= 8'h00;
        stored_channel_value[i] <= `QDSC_STORED_VAL_RST;
      end
      live_output_control <= 8'h00;
      stored_output_control <= `QDSC_STORED_CTRL_RST;
      init_cnt_q <= 20'h0_0000;
      init_busy_q <= 1'b1;
    end else if (clk_en) begin
      // Power-on copy of stored bytes, outputs muted meanwhile
      if (init_busy_q) begin
        for (i = 0; i < 4; i = i + 1) begin
          live_channel_value[i] <= stored_channel_value[i];
        end
        live_output_control <= stored_output_control;
        if (init_cnt_q == INIT_CYCLES - 1) begin
          init_busy_q <= 1'b0;
        end else begin
          init_cnt_q <= init_cnt_q + 20'h0_0001;
        end
      end
      if (scl_rise) begin
        pulse_cnt_q <= pulse_cnt_q + 8'h01;
      end
      if (start_ev) begin
        // START or repeated START always restarts address capture
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        ack_q <= 1'b0;
        rd_ack_q <= 1'b0;
        pulse_cnt_q <= 8'h00;
      end else if (stop_ev) begin
        // Early STOP drops any partial write
        state_q <= ST_IDLE;
        ack_q <= 1'b0;
        rd_ack_q <= 1'b0;
        cmd_valid_q <= 1'b0;
      end else if (scl_rise && state_q != ST_IDLE) begin
        if (bit_cnt_q == 4'h8) begin
          // Ninth pulse: master acknowledge on read data
          bit_cnt_q <= 4'h0;
          if (rd_ack_q && sda_q) begin
            state_q <= ST_IDLE;
          end
        end else begin
          shift_q <= wr_byte;
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end else if (scl_fall && state_q != ST_IDLE) begin
        if (bit_cnt_q == 4'h8) begin
          // Byte received: decide acknowledge
          case (state_q)
            ST_ADDR: begin
              if (shift_q[7:5] == `QDSC_ADDR_FIXED &&
                  shift_q[4:1] == address_strap_pins) begin
                ack_q <= 1'b1;
                if (shift_q[0]) begin
                  state_q <= ST_READ;
                  tx_q <= read_pick(cmd_q, live_flat, stored_flat,
                                    live_output_control, stored_output_control);
                end else begin
                  state_q <= ST_CMD;
                end
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_CMD: begin
              ack_q <= 1'b1;
              cmd_q <= shift_q;
              cmd_valid_q <= cmd_ok(shift_q) & (shift_q[7:6] == `QDSC_CMD_READ);
              state_q <= ST_DATA;
            end
            ST_DATA: begin
              ack_q <= 1'b1;
              // State kept until the acknowledge has been released
            end
            ST_READ: begin
              ack_q <= 1'b0;
              rd_ack_q <= 1'b1;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end else if (ack_q) begin
          // Acknowledge pulse done, release line
          ack_q <= 1'b0;
          // After the data acknowledge the write is complete; extra bytes
          // are ignored until the next START
          if (state_q == ST_DATA && pulse_cnt_q > `QDSC_CMD_ACK_PULSE) begin
            state_q <= ST_IDLE;
          end
        end else if (state_q == ST_READ) begin
          if (rd_ack_q) begin
            rd_ack_q <= 1'b0;
          end else if (bit_cnt_q != 4'h0) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
      // Commits are held off during the power-on load so the copy from
      // stored bytes cannot be overtaken by a write that lands early.
      // Commit at the 26th rising edge
      if (commit && !init_busy_q) begin
        case (cmd_q[5:4])
          `QDSC_SEL_COPY: begin
            if (cmd_q[3:0] == `QDSC_CH_CTRL) begin
              live_output_control <= stored_output_control;
            end else begin
              live_channel_value[cmd_q[1:0]] <= stored_channel_value[cmd_q[1:0]];
            end
          end
          `QDSC_SEL_LIVE: begin
            if (cmd_q[3:0] == `QDSC_CH_CTRL) begin
              live_output_control <= wr_byte;
            end else if (cmd_q[3:0] == `QDSC_CH_ALL) begin
              for (i = 0; i < 4; i = i + 1) begin
                live_channel_value[i] <= wr_byte;
              end
            end else begin
              live_channel_value[cmd_q[1:0]] <= wr_byte;
            end
          end
          `QDSC_SEL_STORED: begin
            if (cmd_q[3:0] == `QDSC_CH_CTRL) begin
              stored_output_control <= wr_byte;
            end else begin
              stored_channel_value[cmd_q[1:0]] <= wr_byte;
            end
          end
          default: begin
            if (cmd_q[3:0] == `QDSC_CH_CTRL) begin
              stored_output_control <= wr_byte;
              live_output_control <= wr_byte;
            end else begin
              stored_channel_value[cmd_q[1:0]] <= wr_byte;
              live_channel_value[cmd_q[1:0]] <= wr_byte;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Pin and converter outputs
  // ----------------------------------------
  // Drive low on acknowledge or a zero read bit; otherwise release
  // The data output is tied low and only the enable moves, as for any
  // open-drain pin; an invalid read command leaves the line released,
  // so the master reads all ones.
  // Converter codes show the live bytes even while muted; the mute flag
  // alone forces the analog level, so unmuting restores the value.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0; // Open drain: never drives high
      sda_oe_b <= 1'b1;
      dac_code <= 32'h0000_0000;
      dac_muted <= 4'hf;
      dac_powered_down <= 4'h0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      sda_oe_b <= ~(ack_q | (state_q == ST_READ && !rd_ack_q && !ack_q &&
                  cmd_valid_q && !tx_q[7]));
      dac_code <= live_flat;
      // Mute nibble, pin or power-on hold forces low reference
      dac_muted <= live_output_control[7:4] | {4{mute_sync_q[1] | init_busy_q}};
      dac_powered_down <= live_output_control[3:0];
    end
  end

endmodule

/* File: tb/qdsc_port_properties.sv */
// Port-level assertions for the quad DAC command port
`timescale 1ns/1ps
`include "qdsc_consts.vh"
module qdsc_port_properties #(
  parameter INIT_CYCLES = 20
) (
  // Clock, reset, enable
  input wire clock,
  input wire rst_b,
  input wire clk_en,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_b,
  // Straps and mute pin
  input wire [3:0] address_strap_pins,
  input wire mute_pin_b,
  // Converter drive
  input wire [31:0] dac_code,
  input wire [3:0] dac_muted,
  input wire [3:0] dac_powered_down
);
  reg [15:0] init_cnt_q; // Cycles since reset release, saturating
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Saturate well past the init period so the end check sees one cycle
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_q <= 16'h0000;
    end else if (clk_en && init_cnt_q < INIT_CYCLES + 8) begin
      init_cnt_q <= init_cnt_q + 16'h0001;
    end
  end
  drive_low_a: assert property (sda_out == 1'b0) else $error("sda_out not low");
  mute_pin_a: assert property (!mute_pin_b |-> ##[0:2] dac_muted == 4'hf)
    else $error("mute pin ignored");
  ack_edge_a: assert property ($fell(sda_oe_b) |-> !scl_in) else $error("pull in high");
  rel_edge_a: assert property ($rose(sda_oe_b) |-> !scl_in) else $error("release high");
  ack_ahead_a: assert property ($fell(sda_oe_b) |-> ##[1:8] scl_in)
    else $error("no clock after pull");
  ack_hold_a: assert property ($rose(scl_in) && !sda_oe_b |-> !sda_oe_b [*3])
    else $error("pull not held");
  muted_code_a: assert property ($fell(dac_muted[0]) |-> $stable(dac_code[7:0]))
    else $error("code moved at unmute");
  reset_vals_a: assert property ($rose(rst_b) |-> dac_code == 32'h0000_0000 && sda_oe_b)
    else $error("bad reset outputs");
  init_mute_a: assert property (init_cnt_q < INIT_CYCLES |-> dac_muted == 4'hf)
    else $error("init not muted");
  init_end_a: assert property (init_cnt_q == INIT_CYCLES + 4 && mute_pin_b |->
    dac_muted == 4'h0 && dac_powered_down == 4'h0) else $error("bad init state");
endmodule
bind qdsc_port qdsc_port_properties #(.INIT_CYCLES(INIT_CYCLES)) qdsc_port_properties_inst (
  .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_b(sda_oe_b), .address_strap_pins(address_strap_pins),
  .mute_pin_b(mute_pin_b), .dac_code(dac_code), .dac_muted(dac_muted),
  .dac_powered_down(dac_powered_down));

/* File: tb/qdsc_master.sv */
// Two-wire bus master model facing the command port
`timescale 1ns/1ps
module qdsc_master (
  // Clock and wired data level
  input wire clock,
  input wire sda_line,
  // Open-drain lines, 1 means released
  output reg scl,
  output reg sda_drv,
  // Received ack or byte, with strobe
  output reg [7:0] got,
  output reg got_v
);
  integer k; // Bit index
  reg s; // Last sampled data level
  reg [8:0] r; // Shift image of one byte slot
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    got = 8'h00;
    got_v = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // One 80 ns clock: long low so the synchronised slave can answer in time
  task bit_io(input b);
    begin
      scl = 1'b0;
      tick(2);
      sda_drv = b;
      tick(5);
      scl = 1'b1;
      tick(3);
      s = sda_line;
    end
  endtask
  // START, or repeated START while the bus is held
  task start;
    begin
      bit_io(1'b1);
      sda_drv = 1'b0;
      tick(3);
    end
  endtask
  task stop;
    begin
      bit_io(1'b0);
      sda_drv = 1'b1;
      tick(5);
    end
  endtask
  // Nine clocks; reads release every bit and end with a NACK
  task xb(input [7:0] x, input rdb);
    begin
      r = rdb ? 9'h1ff : {x, 1'b1};
      for (k = 8; k >= 0; k = k - 1) begin
        bit_io(r[k]);
        r[k] = s;
      end
      got = rdb ? r[8:1] : {7'h00, r[0]};
      got_v = 1'b1;
      tick(1);
      got_v = 1'b0;
    end
  endtask
endmodule

/* File: tb/qdsc_port_tb.sv */
// Self-checking bench for the quad DAC command port
`timescale 1ns/1ps
`include "qdsc_consts.vh"
`define CHK(n, e, v) begin samples_checked = samples_checked + 1; \
  if ((v) !== (e)) begin fail_count = fail_count + 1; \
  $display("MISMATCH %s exp %h got %h", n, e, v); end end
module qdsc_port_tb;
  reg clock, rst_b, mute_pin_b;
  reg [3:0] straps;
  integer seed, fail_count, samples_checked, cycles, i, rn;
  reg [7:0] v, e;
  reg [7:0] exp_q [$];
  reg [31:0] code_e;
  reg [7:0] ctl_e;
  wire sda_out, sda_oe_b, scl, m_sda, got_v, sda;
  wire [31:0] dac_code;
  wire [3:0] dac_muted, dac_powered_down;
  wire [7:0] got;
  wire [7:0] aw = {`QDSC_ADDR_FIXED, straps, 1'b0};
  // Open-drain wired level, pulled up when released
  assign sda = m_sda & (sda_oe_b | sda_out);
  qdsc_port #(.INIT_CYCLES(20)) qdsc_port_inst (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .address_strap_pins(straps), .mute_pin_b(mute_pin_b), .dac_code(dac_code),
    .dac_muted(dac_muted), .dac_powered_down(dac_powered_down));
  qdsc_master qdsc_master_inst (.clock(clock), .sda_line(sda), .scl(scl), .sda_drv(m_sda),
    .got(got), .got_v(got_v));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Oldest note is compared against each ack or byte seen
  always @(posedge got_v) begin
    e = exp_q.pop_front();
    `CHK("bus", e, got)
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  task note(input [7:0] x);
    exp_q.push_back(x);
  endtask
  task chk_out;
    begin
      qdsc_master_inst.tick(4);
      `CHK("code", code_e, dac_code)
      `CHK("ctl", ctl_e, {dac_muted, dac_powered_down})
    end
  endtask
  task wr(input [7:0] c, input [7:0] d);
    begin
      repeat (3) note(8'h00);
      qdsc_master_inst.start;
      qdsc_master_inst.xb(aw, 1'b0);
      qdsc_master_inst.xb(c, 1'b0);
      qdsc_master_inst.xb(d, 1'b0);
      qdsc_master_inst.stop;
      chk_out;
    end
  endtask
  task rd(input [7:0] c, input [7:0] x);
    begin
      repeat (3) note(8'h00);
      note(x);
      qdsc_master_inst.start;
      qdsc_master_inst.xb(aw, 1'b0);
      qdsc_master_inst.xb(c, 1'b0);
      qdsc_master_inst.start;
      qdsc_master_inst.xb(aw | 8'h01, 1'b0);
      qdsc_master_inst.xb(8'hff, 1'b1);
      qdsc_master_inst.stop;
    end
  endtask
  // Address that must go unanswered, or a write cut short after the command
  task probe(input [7:0] a, input [7:0] c);
    begin
      note(a == aw ? 8'h00 : 8'h01);
      qdsc_master_inst.start;
      qdsc_master_inst.xb(a, 1'b0);
      if (a == aw) begin
        note(8'h00);
        qdsc_master_inst.xb(c, 1'b0);
      end
      qdsc_master_inst.stop;
      chk_out;
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h8ab1;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    rst_b = 1'b0;
    mute_pin_b = 1'b1;
    rn = $random(seed);
    straps = rn[3:0];
    code_e = 32'h0000_0000;
    ctl_e = 8'h00;
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    repeat (40) @(negedge clock);
    rd(8'ha4, 8'h00);
    rd(8'ha1, 8'h00);
    probe({`QDSC_ADDR_FIXED, straps ^ 4'h1, 1'b0}, 8'h00);
    probe(8'h00, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      rn = $random(seed);
      code_e[8*i +: 8] = rn[7:0];
      wr({4'h1, i[3:0]}, rn[7:0]);
    end
    rn = $random(seed);
    v = rn[7:0];
    wr(8'h22, v);
    rd(8'ha2, v);
    code_e[23:16] = v;
    wr(8'h02, 8'h00);
    code_e = 32'h5a5a_5a5a;
    wr(8'h1f, 8'h5a);
    code_e[7:0] = 8'hc3;
    wr(8'h30, 8'hc3);
    rd(8'h90, 8'hc3);
    rd(8'ha0, 8'hc3);
    probe(aw, 8'h31);
    wr(8'h41, 8'h77);
    ctl_e = 8'h12;
    wr(8'h14, 8'h12);
    code_e[7:0] = 8'h99;
    wr(8'h10, 8'h99);
    rd(8'h90, 8'h99);
    ctl_e = 8'h00;
    wr(8'h14, 8'h00);
    wr(8'h24, 8'h80);
    ctl_e = 8'h80;
    wr(8'h04, 8'h00);
    rd(8'h94, 8'h80);
    ctl_e = 8'h00;
    wr(8'h14, 8'h00);
    mute_pin_b = 1'b0;
    qdsc_master_inst.tick(3);
    `CHK("mute", 4'hf, dac_muted)
    mute_pin_b = 1'b1;
    chk_out;
    finish_test;
  end
endmodule
